// ---- shh_pkg.sv ----
// Constants and carrier types for the sorting handler handshake block.
// Assumes a single 40 MHz system clock; pins are synchronised inside.
// Summary of operation
// - Every line marked with the slash prefix is asserted when low.
// - Output and input lines change meaning between single sort and list sweep; here list_sweep_mode_i changes only busy_o.
// - With external start selected, a rising start edge begins a measurement; the pulse is at least 1 us.
// - Measurement begins no sooner than 200 us and no later than 200 us plus display update time after start.
// - Analog-phase-done asserts when analog work ends; data is not valid before result-valid.
// - Result-valid asserts only after data and every judgment are valid.
// - About 1 ms of comparison separates analog-phase-done and result-valid.
// - Nine sort-class lines plus no-class-match and auxiliary lines are active-low outputs.
// - Primary-above-limit asserts when the primary value exceeds the top class limit.
// - Primary-below-limit asserts when the primary value is below the bottom class limit.
// - Secondary-outside-limit asserts when the secondary value leaves its range.
// - The bridge imbalance flag asserts whenever the bridge fails to balance.
// - While lockout is asserted, all front-panel keys are ignored.
// - The power-fail alarm asserts when a power failure is detected.
package shh_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned START_DLY_US = 200;
  localparam int unsigned MIN_PULSE_US = 1;
  localparam int unsigned COMPARE_US   = 1000;
  localparam int unsigned START_DLY_CYC = START_DLY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned COMPARE_CYC   = COMPARE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned NUM_CLASS = 9;

  typedef enum logic [2:0] {
    SHH_IDLE    = 3'h0,
    SHH_DELAY   = 3'h1,
    SHH_ANALOG  = 3'h2,
    SHH_COMPARE = 3'h3,
    SHH_DONE    = 3'h4
  } shh_state_e;

  // Judgment results from the measuring core, active high
  typedef struct packed {
    logic [NUM_CLASS-1:0] sort_class_1_to_9;
    logic                 no_class_match;
    logic                 aux_class;
    logic                 primary_above_limit;
    logic                 primary_below_limit;
    logic                 secondary_outside_limit;
    logic                 bridge_imbalance_flag;
  } shh_judge_s;
endpackage

// ---- shh_handshake.sv ----
// Handler handshake: start sequencing, phase strobes and judgment pins.
// Assumes the measuring core reports analog end and judgment results on
// clk_sys_i; handler pins are asynchronous and synchronised here.
`timescale 1ns/1ps
module shh_handshake (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      external_start_pulse_n_i,
  input  wire logic                      external_start_source_i,
  input  wire logic                      list_sweep_mode_i,
  input  wire logic                      internal_start_i,
  input  wire logic [shh_pkg::CNT_W-1:0] display_cyc_i,
  input  wire logic                      analog_done_i,
  input  wire shh_pkg::shh_judge_s       judge_i,
  input  wire logic                      key_lockout_n_i,
  input  wire logic                      key_press_i,
  input  wire logic                      power_fail_i,
  output logic                           meas_start_o,
  output logic                           key_accept_o,
  output logic                           analog_phase_done_n_o,
  output logic                           result_valid_strobe_n_o,
  output shh_pkg::shh_judge_s            judge_n_o,
  output logic                           power_fail_alarm_n_o,
  output logic                           busy_o
);
  import shh_pkg::*;

  logic [1:0]       start_sync_reg;
  logic [1:0]       lock_sync_reg;
  logic [1:0]       pfail_sync_reg;
  logic             start_prev_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic             pulse_ok_reg;
  shh_state_e       state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] dly_target_reg;
  logic             start_lvl;
  logic             start_rise;
  logic             trig;
  logic             trig_taken;
  logic             delay_end;
  logic             compare_end;

  // True on the cycle that completes a count of target cycles; one
  // helper keeps the pulse, delay and compare end points consistent
  function automatic logic count_reached(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] target
  );
    count_reached = (cnt + 1'b1) >= target;
  endfunction

  // Start pin crosses in through two flops; idles high so reset is quiet
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      start_sync_reg <= 2'h3;
    else
      start_sync_reg <= {start_sync_reg[0], external_start_pulse_n_i};
  end

  // Lockout pin, two flops; idles released
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      lock_sync_reg <= 2'h3;
    else
      lock_sync_reg <= {lock_sync_reg[0], key_lockout_n_i};
  end

  // Power-fail detector, two flops; idles clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      pfail_sync_reg <= 2'h0;
    else
      pfail_sync_reg <= {pfail_sync_reg[0], power_fail_i};
  end

  assign start_lvl   = start_sync_reg[1];
  assign delay_end   = (state_reg == SHH_DELAY)
                     && count_reached(cnt_reg, dly_target_reg);
  assign compare_end = (state_reg == SHH_COMPARE)
                     && count_reached(cnt_reg, CNT_W'(COMPARE_CYC));

  // Previous level for the edge detector; resets to the idle level so the
  // release of reset never looks like a rising edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      start_prev_reg <= 1'h1;
    else
      start_prev_reg <= start_lvl;
  end

  // Width of the low phase is measured so glitches do not start a cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_reg  <= '0;
      pulse_ok_reg <= 1'h0;
    end else begin
      if (!start_lvl) begin
        if (low_cnt_reg < CNT_W'(MIN_PULSE_CYC))
          low_cnt_reg <= low_cnt_reg + 1'b1;
        pulse_ok_reg <= count_reached(low_cnt_reg, CNT_W'(MIN_PULSE_CYC));
      end else begin
        low_cnt_reg  <= '0;
        pulse_ok_reg <= 1'h0;
      end
    end
  end

  // Rising edge of the active-low pulse ends it and fires the trigger
  assign start_rise = start_lvl && !start_prev_reg && pulse_ok_reg;
  assign trig       = external_start_source_i ? start_rise
                                              : internal_start_i;
  // Taken only in idle or once the result is out, so back to back is ok;
  // triggers during a running measurement are dropped
  assign trig_taken = trig
                    && (state_reg == SHH_IDLE || state_reg == SHH_DONE);

  // Start delay target is captured as the trigger is taken, so a display
  // time that changes mid-delay cannot shorten the floor
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      dly_target_reg <= '0;
    else if (trig_taken)
      dly_target_reg <= CNT_W'(START_DLY_CYC) + display_cyc_i;
  end

  // Phase sequencing; the counter is shared by the delay and compare phases
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SHH_IDLE;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        SHH_IDLE, SHH_DONE: begin
          if (trig) begin
            state_reg <= SHH_DELAY;
            cnt_reg   <= '0;
          end
        end
        SHH_DELAY: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Display time is at most added; never shorter than the floor
          if (delay_end) begin
            state_reg <= SHH_ANALOG;
            cnt_reg   <= '0;
          end
        end
        SHH_ANALOG: begin
          if (analog_done_i) begin
            state_reg <= SHH_COMPARE;
            cnt_reg   <= '0;
          end
        end
        SHH_COMPARE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (compare_end) begin
            state_reg <= SHH_DONE;
          end
        end
        // Unused codes fall back to idle rather than lock up
        default: begin
          state_reg <= SHH_IDLE;
          cnt_reg   <= '0;
        end
      endcase
    end
  end

  // Start strobe toward the measuring core, one cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      meas_start_o <= 1'h0;
    else
      meas_start_o <= delay_end;
  end

  // Judgments latched inverted at the end of comparison and held until
  // the next result; the pins come straight from flops, free of glitches
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      judge_n_o <= '1;
    else if (compare_end)
      judge_n_o <= ~judge_i;
  end

  // Analog-phase-done stays asserted through comparison and result; the
  // handler may swap the part from here on
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      analog_phase_done_n_o <= 1'h1;
    else
      analog_phase_done_n_o <= !(state_reg == SHH_COMPARE
                                 || state_reg == SHH_DONE);
  end

  // Result-valid trails the judgment latch by one edge, so a handler that
  // samples on the strobe never sees the previous judgments
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      result_valid_strobe_n_o <= 1'h1;
    else
      result_valid_strobe_n_o <= !(state_reg == SHH_DONE);
  end

  // Alarm follows the synchronised detector level, no latching
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      power_fail_alarm_n_o <= 1'h1;
    else
      power_fail_alarm_n_o <= !pfail_sync_reg[1];
  end

  // Key presses pass only while the synchronised lockout is released
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      key_accept_o <= 1'h0;
    else
      key_accept_o <= key_press_i && lock_sync_reg[1];
  end

  // In list sweep, busy covers only the start delay; the per-step phases
  // are reported on the strobes instead
  assign busy_o = ((state_reg != SHH_IDLE) && (state_reg != SHH_DONE)
                   && !list_sweep_mode_i)
                || (state_reg == SHH_DELAY);
endmodule

// ---- shh_handler_model.sv ----
// Handler model: drives the active-low start pin with one pulse per go_i.
// Assumes go_i is raised off the sampling edge by the bench.
`timescale 1ns/1ps
module shh_handler_model (
  input  wire logic       clk_sys_i,
  input  wire logic       go_i,
  input  wire logic [7:0] low_cyc_i,
  output logic            pin_n_o
);
  initial pin_n_o = 1'b1;
  // Pin idles high; the rising edge ends the pulse and is the trigger
  always @(posedge go_i) begin
    @(negedge clk_sys_i);
    pin_n_o <= 1'b0;
    repeat (low_cyc_i) @(negedge clk_sys_i);
    pin_n_o <= 1'b1;
  end
endmodule

// ---- shh_handshake_chk.sv ----
// Checker for the handler handshake block.
// Assumes it is bound to shh_handshake and sees only its ports.
`timescale 1ns/1ps
module shh_handshake_chk (
  input wire logic clk_sys_i, rst_i, analog_done_i, power_fail_i,
  input wire logic key_lockout_n_i, key_press_i, key_accept_o,
  input wire logic meas_start_o, analog_phase_done_n_o,
  input wire logic result_valid_strobe_n_o, power_fail_alarm_n_o,
  input wire shh_pkg::shh_judge_s judge_n_o
);
  import shh_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [31:0] gap_reg;
  logic        ana_reg;
  // Cycles spent with analog-phase-done asserted
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) gap_reg <= '0;
    else gap_reg <= analog_phase_done_n_o ? '0 : gap_reg + 32'h1;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) ana_reg <= 1'b0;
    else ana_reg <= meas_start_o | (ana_reg & ~analog_done_i);
  sequence s_valid; $fell(result_valid_strobe_n_o); endsequence
  property p_lock; !key_lockout_n_i[*4] ##0 key_press_i |=> !key_accept_o;
  endproperty
  property p_free; key_lockout_n_i[*4] ##0 key_press_i |=> key_accept_o;
  endproperty
  property p_pf; power_fail_i[*4] |-> !power_fail_alarm_n_o; endproperty
  property p_ok; !power_fail_i[*4] |-> power_fail_alarm_n_o; endproperty
  property p_idx; analog_done_i && ana_reg |-> ##2 !analog_phase_done_n_o;
  endproperty
  property p_cmp; s_valid |-> gap_reg >= COMPARE_CYC - 1 &&
    gap_reg <= COMPARE_CYC + 2; endproperty
  property p_ord; !result_valid_strobe_n_o |-> !analog_phase_done_n_o;
  endproperty
  property p_jdg; $changed(judge_n_o) |-> ##[0:1] s_valid; endproperty
  property p_clr; meas_start_o |-> analog_phase_done_n_o &&
    result_valid_strobe_n_o; endproperty
  a_lock: assert property (p_lock) else $error("key taken in lockout");
  a_free: assert property (p_free) else $error("key lost");
  a_pf: assert property (p_pf) else $error("alarm missing");
  a_ok: assert property (p_ok) else $error("alarm stuck");
  a_idx: assert property (p_idx) else $error("index late");
  a_cmp: assert property (p_cmp) else $error("compare time");
  a_ord: assert property (p_ord) else $error("valid before index");
  a_jdg: assert property (p_jdg) else $error("judgment moved");
  a_clr: assert property (p_clr) else $error("strobes not cleared");
endmodule
bind shh_handshake shh_handshake_chk shh_handshake_chk_i (.clk_sys_i,
  .rst_i, .analog_done_i, .power_fail_i, .key_lockout_n_i, .key_press_i,
  .key_accept_o, .meas_start_o, .analog_phase_done_n_o,
  .result_valid_strobe_n_o, .power_fail_alarm_n_o, .judge_n_o);

// ---- tb_top.sv ----
// Testbench: handler model on the start pin, bench plays the core.
// Assumes the 1 ms compare time of the package; one full cycle only.
`timescale 1ns/1ps
module tb_top;
  import shh_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, ext_src = 1, mode = 0, istart = 0;
  logic adone = 0, lk_n = 1, kp = 0, pf = 0, go = 0, pin_n;
  logic ms, acc, idx_n, val_n, al_n, busy;
  logic [CNT_W-1:0] disp = '0;
  logic [7:0] lowc = 8'h0a;
  shh_judge_s jdg = '0, jn;
  int n_fail = 0, cmp_count = 0, t;
  always #12.5 clk_sys_i = ~clk_sys_i;
  shh_handler_model shh_handler_model_i (.clk_sys_i, .go_i(go),
    .low_cyc_i(lowc), .pin_n_o(pin_n));
  shh_handshake shh_handshake_i (.clk_sys_i, .rst_i,
    .external_start_pulse_n_i(pin_n), .external_start_source_i(ext_src),
    .list_sweep_mode_i(mode), .internal_start_i(istart),
    .display_cyc_i(disp), .analog_done_i(adone), .judge_i(jdg),
    .key_lockout_n_i(lk_n), .key_press_i(kp), .power_fail_i(pf),
    .meas_start_o(ms), .key_accept_o(acc), .analog_phase_done_n_o(idx_n),
    .result_valid_strobe_n_o(val_n), .judge_n_o(jn),
    .power_fail_alarm_n_o(al_n), .busy_o(busy));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n); repeat (n) @(negedge clk_sys_i); endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    final_report;
  end
  initial begin
    t = $urandom(32'h4743);
    cyc(12);
    rst_i = 0;
    cyc(4);
    chk("judge_idle", 15'h7fff, jn);
    for (int i = 0; i < 2; i++) begin
      lk_n = i[0];
      pf = ~i[0];
      cyc(4);
      kp = 1;
      cyc(1);
      kp = 0;
      chk("key_accept", i, acc);
      chk("alarm_n", i, al_n);
    end
    $display("test keys and alarm done");
    go = 1;
    cyc(1);
    go = 0;
    t = 0;
    repeat (8200) begin cyc(1); t += ms; end
    chk("short_pulse", 0, t);
    $display("test short pulse done");
    disp = $urandom_range(63);
    lowc = 8'(40 + $urandom_range(100));
    jdg = shh_judge_s'($urandom);
    mode = 1'($urandom);
    go = 1;
    cyc(1);
    go = 0;
    cyc(lowc);
    t = 0;
    while (ms !== 1'b1 && t < 9000) begin cyc(1); t++; end
    chk("start_delay", 1, t >= START_DLY_CYC + disp &&
      t <= START_DLY_CYC + disp + 6);
    cyc(3);
    adone = 1;
    cyc(1);
    adone = 0;
    cyc(3);
    chk("index_n", 0, idx_n);
    chk("valid_n_early", 1, val_n);
    chk("busy_compare", !mode, busy);
    t = 0;
    while (val_n !== 1'b0 && t < 41000) begin cyc(1); t++; end
    chk("compare_time", 1, t >= COMPARE_CYC - 6 && t <= COMPARE_CYC + 2);
    chk("judge_n", shh_judge_s'(~jdg), jn);
    chk("busy_done", 0, busy);
    $display("test measurement done");
    ext_src = 0;
    istart = 1;
    cyc(1);
    istart = 0;
    cyc(4);
    chk("index_clear", 1, idx_n);
    chk("valid_clear", 1, val_n);
    chk("judge_hold", shh_judge_s'(~jdg), jn);
    chk("busy_delay", 1, busy);
    $display("test retrigger done");
    final_report;
  end
endmodule
